// >>> verilog/escr_pkg.sv
// Constants and types for the exception status and cause logic
// How it works
// (RULE1) Status bit 4 shows user mode; either level forces kernel mode.
// (RULE2) Status bit 3 ignores writes and reads zero.
// (RULE3) Error level, bit 2, set by reset-class exceptions; resets to 1.
// (RULE4) Error level means kernel, interrupts off, return via error PC.
// (RULE5) Error level makes the user segment unmapped and uncached; the code gives only an unmapped flag, no uncached output.
// (RULE6) Exception level, bit 1, set by every other exception.
// (RULE7) Exception level means kernel, interrupts off, return PC held.
// (RULE8) Refill taken at exception level uses the general vector.
// (RULE9) Status bit 0 is the master enable for all interrupts.
// (RULE10) Only cause software requests, vector select, watch pending write.
// (RULE11) Cause bit 31 marks delay slot; frozen while exception level.
// (RULE12) Cause bits 29:28 load the coprocessor number on every exception.
// (RULE13) Cause bit 23 picks vector 0x180 or 0x200 for interrupts.
// (RULE14) Watch at either level sets bit 22; raised once both clear.
// (RULE15) Software may only clear the watch pending bit.
// (RULE16) Handler software must clear watch pending, else it loops.
// (RULE17) Cause bits 15:10 are read-only hardware interrupt pending.
// (RULE18) Cause bits 9:8 are writable software interrupt requests.
// (RULE19) Cause bits 6:2 hold the last exception code.
// (RULE20) Cause bits 30, 27:24, 21:16, 7, 1:0 read zero.
// (RULE21) Interrupt only if enabled and some mask and pending bit match.
// (RULE22) Exception codes follow the fixed encoding below.
// (RULE23) Hardware pending bits follow synchronised interrupt pins.
package escr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] STATUS_OFF  = 8'h00;
  localparam logic [7:0] CAUSE_OFF   = 8'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_IE  = 0;
  localparam int ST_EXL = 1;
  localparam int ST_ERL = 2;
  localparam int ST_UM  = 4;
  localparam int ST_IM  = 8;
  localparam int CA_EXC = 2;
  localparam int CA_SW  = 8;
  localparam int CA_HW  = 10;
  localparam int CA_WP  = 22;
  localparam int CA_IV  = 23;
  localparam int CA_CE  = 28;
  localparam int CA_BD  = 31;
  localparam int HW_N   = 6;

  localparam logic [31:0] CAUSE_ZERO_MASK = 32'h4F3F_0083; // [RULE20]

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic ERL_RST = 1'b1;
  localparam logic LVL_RST = 1'b0;

  // ****************************************************************
  // Exception codes and vector offsets
  // ****************************************************************
  localparam logic [4:0] EXC_INT   = 5'h00; // [RULE22]
  localparam logic [4:0] EXC_ADEL  = 5'h04;
  localparam logic [4:0] EXC_ADES  = 5'h05;
  localparam logic [4:0] EXC_IBE   = 5'h06;
  localparam logic [4:0] EXC_DBE   = 5'h07;
  localparam logic [4:0] EXC_SYS   = 5'h08;
  localparam logic [4:0] EXC_BP    = 5'h09;
  localparam logic [4:0] EXC_RI    = 5'h0A;
  localparam logic [4:0] EXC_CPU   = 5'h0B;
  localparam logic [4:0] EXC_OV    = 5'h0C;
  localparam logic [4:0] EXC_TR    = 5'h0D;
  localparam logic [4:0] EXC_WATCH = 5'h17;
  localparam logic [4:0] EXC_MCHK  = 5'h18;

  localparam logic [11:0] VEC_GENERAL = 12'h180;
  localparam logic [11:0] VEC_INT     = 12'h200;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       take;
    logic       reset_class;
    logic       refill;
    logic       delay_slot;
    logic [1:0] cop;
    logic [4:0] code;
  } escr_exc_t;

  typedef struct packed {
    logic        kernel_mode;
    logic        int_req;
    logic        exception_return_instr_use_error;
    logic        epc_hold;
    logic        useg_unmapped;
    logic        watch_req;
    logic        refill_general;
    logic [11:0] int_vec_offset;
  } escr_ctl_t;

  typedef struct packed {
    logic [7:0]  interrupt_mask;
    logic        user_mode_flag;
    logic        error_level;
    logic        exception_level;
    logic        interrupt_master_enable;
    logic        delay_slot_flag;
    logic [1:0]  cop_num;
    logic        interrupt_vector_select;
    logic        watch_pending;
    logic [1:0]  sw_interrupt_request;
    logic [4:0]  exc_code;
    logic [31:0] rd_data;
    escr_ctl_t   ctl;
  } escr_state_t;

endpackage

// >>> verilog/escr_irq_sync.sv
// Two-stage synchroniser for the hardware interrupt pins
`timescale 1ns/100ps
module escr_irq_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] irq_pin,
  output logic      [W-1:0] irq_level
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } escr_sync_t;

  escr_sync_t st_ff;
  escr_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = irq_pin;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign irq_level = st_ff.sync;

endmodule

// >>> verilog/escr_regs.sv
// Status low bits and cause register with exception capture
`timescale 1ns/100ps
module escr_regs #(
  parameter int HW_IRQS = escr_pkg::HW_N
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [escr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire escr_pkg::escr_exc_t         exc_in,
  input  wire logic                       exception_return_instr,
  input  wire logic                       watch_match,
  input  wire logic [HW_IRQS-1:0]         hw_irq_pin,
  output escr_pkg::escr_ctl_t             ctl_out
);

  // ****************************************************************
  // Interrupt pin synchronisation
  // ****************************************************************
  logic [HW_IRQS-1:0] hw_interrupt_pending;

  escr_irq_sync #(
    .W         (HW_IRQS)
  ) u_sync ( // [RULE23]
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .irq_pin   (hw_irq_pin),
    .irq_level (hw_interrupt_pending)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  escr_pkg::escr_state_t st_ff;
  escr_pkg::escr_state_t nxt_st;

  logic        wr_status;
  logic        wr_cause;
  logic [31:0] status_view;
  logic [31:0] cause_view;
  logic [7:0]  pend_all;
  logic        any_level;

  // ****************************************************************
  // Read views
  // ****************************************************************
  always_comb begin
    status_view = '0;
    status_view[escr_pkg::ST_IM +: 8]  = st_ff.interrupt_mask;
    status_view[escr_pkg::ST_UM]       = st_ff.user_mode_flag; // [RULE1]
    status_view[escr_pkg::ST_ERL]      = st_ff.error_level;
    status_view[escr_pkg::ST_EXL]      = st_ff.exception_level;
    status_view[escr_pkg::ST_IE]       = st_ff.interrupt_master_enable;
    // Bit 3 is never assigned, so it reads zero [RULE2]
  end

  always_comb begin
    cause_view = '0; // Unassigned bits read zero [RULE20]
    cause_view[escr_pkg::CA_BD]        = st_ff.delay_slot_flag;
    cause_view[escr_pkg::CA_CE +: 2]   = st_ff.cop_num;
    cause_view[escr_pkg::CA_IV]        = st_ff.interrupt_vector_select;
    cause_view[escr_pkg::CA_WP]        = st_ff.watch_pending;
    cause_view[escr_pkg::CA_HW +: HW_IRQS] = hw_interrupt_pending; // [RULE17]
    cause_view[escr_pkg::CA_SW +: 2]   = st_ff.sw_interrupt_request;
    cause_view[escr_pkg::CA_EXC +: 5]  = st_ff.exc_code; // [RULE19]
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    wr_status = reg_wr && (reg_addr == escr_pkg::STATUS_OFF);
    wr_cause  = reg_wr && (reg_addr == escr_pkg::CAUSE_OFF);
    nxt_st    = st_ff;

    // Read data stands for one cycle only, zero for unmapped offsets
    nxt_st.rd_data = '0;
    if (reg_rd && reg_addr == escr_pkg::STATUS_OFF) begin
      nxt_st.rd_data = status_view;
    end else if (reg_rd && reg_addr == escr_pkg::CAUSE_OFF) begin
      nxt_st.rd_data = cause_view;
    end

    // Software writes come first; hardware events below override them
    if (wr_status) begin
      nxt_st.interrupt_mask  = reg_wdata[escr_pkg::ST_IM +: 8];
      nxt_st.user_mode_flag  = reg_wdata[escr_pkg::ST_UM];
      nxt_st.error_level     = reg_wdata[escr_pkg::ST_ERL];
      nxt_st.exception_level = reg_wdata[escr_pkg::ST_EXL];
      nxt_st.interrupt_master_enable = reg_wdata[escr_pkg::ST_IE];
    end
    if (wr_cause) begin // [RULE10]
      nxt_st.interrupt_vector_select = reg_wdata[escr_pkg::CA_IV];
      nxt_st.sw_interrupt_request =
        reg_wdata[escr_pkg::CA_SW +: 2]; // [RULE18]
      // Writing one leaves the bit alone; only zero clears it [RULE15]
      nxt_st.watch_pending = st_ff.watch_pending &
                             reg_wdata[escr_pkg::CA_WP];
    end

    // Return drops the error level first, else the exception level
    if (exception_return_instr) begin
      if (st_ff.error_level) begin
        nxt_st.error_level = 1'b0;
      end else begin
        nxt_st.exception_level = 1'b0;
      end
    end

    // Deferred watch: set wins over a clearing write [RULE14]
    if (watch_match && (st_ff.exception_level || st_ff.error_level)) begin
      nxt_st.watch_pending = 1'b1;
    end

    // Exception capture has the last word over writes and returns
    if (exc_in.take) begin
      nxt_st.cop_num  = exc_in.cop; // [RULE12]
      nxt_st.exc_code = exc_in.code; // [RULE19] [RULE22]
      if (!st_ff.exception_level) begin
        nxt_st.delay_slot_flag = exc_in.delay_slot; // [RULE11]
      end
      if (exc_in.reset_class) begin
        nxt_st.error_level = 1'b1; // [RULE3]
      end else begin
        nxt_st.exception_level = 1'b1; // [RULE6]
      end
    end

    // Outputs follow the next state so they match the registers
    any_level = nxt_st.error_level | nxt_st.exception_level;
    pend_all  = '0;
    pend_all[1:0] = nxt_st.sw_interrupt_request;
    pend_all[2 +: HW_IRQS] = hw_interrupt_pending;

    // Either level forces kernel regardless of the user bit [RULE1]
    nxt_st.ctl.kernel_mode = !nxt_st.user_mode_flag | any_level; // [RULE4]
    // Levels mask interrupts; master enable gates the rest [RULE7]
    nxt_st.ctl.int_req = nxt_st.interrupt_master_enable && // [RULE9]
                         !any_level &&
                         |(pend_all & nxt_st.interrupt_mask); // [RULE21]
    nxt_st.ctl.exception_return_instr_use_error = nxt_st.error_level; // [RULE4]
    // Held return PC stops a nested exception losing the first [RULE7]
    nxt_st.ctl.epc_hold       = nxt_st.exception_level;
    nxt_st.ctl.useg_unmapped  = nxt_st.error_level; // [RULE5]
    nxt_st.ctl.refill_general = nxt_st.exception_level; // [RULE8]
    // Keeps firing until the handler clears pending [RULE14] [RULE16]
    nxt_st.ctl.watch_req      = nxt_st.watch_pending && !any_level;
    nxt_st.ctl.int_vec_offset = nxt_st.interrupt_vector_select ?
                                escr_pkg::VEC_INT :
                                escr_pkg::VEC_GENERAL; // [RULE13]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff             <= '0;
      st_ff.error_level <= escr_pkg::ERL_RST; // [RULE3]
      st_ff.exception_level <= escr_pkg::LVL_RST;
      st_ff.ctl.kernel_mode <= 1'b1;
      st_ff.ctl.exception_return_instr_use_error <= 1'b1;
      st_ff.ctl.useg_unmapped  <= 1'b1;
      st_ff.ctl.int_vec_offset <= escr_pkg::VEC_GENERAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rd_data;
  assign ctl_out   = st_ff.ctl;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_reset_exc;
    exc_in.take && exc_in.reset_class;
  endsequence

  sequence s_other_exc;
    exc_in.take && !exc_in.reset_class;
  endsequence

  sequence s_watch_deferred;
    watch_match && (st_ff.exception_level || st_ff.error_level);
  endsequence

  sequence s_status_read;
    reg_rd && reg_addr == escr_pkg::STATUS_OFF;
  endsequence

  sequence s_cause_read;
    reg_rd && reg_addr == escr_pkg::CAUSE_OFF;
  endsequence

  sequence s_cause_write;
    wr_cause && !exc_in.take;
  endsequence

  sequence s_return_at_error;
    exception_return_instr && st_ff.error_level && !exc_in.take;
  endsequence

  chk_kernel_forced: assert property ( // [RULE1]
    ctl_out.kernel_mode ==
      (!st_ff.user_mode_flag || st_ff.error_level ||
       st_ff.exception_level))
    else $error("kernel mode not derived from levels");

  chk_bit3_zero: assert property ( // [RULE2]
    s_status_read |=> reg_rdata[3] == 1'b0)
    else $error("status bit 3 read nonzero");

  chk_erl_set: assert property ( // [RULE3]
    s_reset_exc |=> st_ff.error_level && ctl_out.exception_return_instr_use_error &&
                    ctl_out.useg_unmapped)
    else $error("error level not set by reset exception");

  chk_exl_set: assert property ( // [RULE6]
    s_other_exc |=> st_ff.exception_level && ctl_out.epc_hold &&
                    ctl_out.refill_general)
    else $error("exception level not set by exception");

  chk_levels_mask: assert property ( // [RULE7]
    (st_ff.exception_level || st_ff.error_level) |-> !ctl_out.int_req)
    else $error("interrupt requested at raised level");

  chk_bd_frozen: assert property ( // [RULE11]
    exc_in.take && st_ff.exception_level |=> $stable(st_ff.delay_slot_flag))
    else $error("delay slot flag changed at exception level");

  chk_bd_loaded: assert property ( // [RULE11]
    exc_in.take && !st_ff.exception_level
      |=> st_ff.delay_slot_flag == $past(exc_in.delay_slot))
    else $error("delay slot flag not captured");

  chk_ce_code_load: assert property ( // [RULE12]
    exc_in.take |=> st_ff.cop_num == $past(exc_in.cop) &&
                    st_ff.exc_code == $past(exc_in.code))
    else $error("coprocessor number or code not captured");

  chk_vec_select: assert property ( // [RULE13]
    wr_cause && !exc_in.take |=>
      ctl_out.int_vec_offset ==
        ($past(reg_wdata[escr_pkg::CA_IV]) ?
         escr_pkg::VEC_INT : escr_pkg::VEC_GENERAL))
    else $error("interrupt vector offset wrong");

  chk_wp_defer: assert property ( // [RULE14]
    s_watch_deferred |=> st_ff.watch_pending)
    else $error("deferred watch not recorded");

  chk_wp_raise: assert property ( // [RULE14]
    st_ff.watch_pending && !st_ff.exception_level &&
    !st_ff.error_level |-> ctl_out.watch_req)
    else $error("deferred watch not raised");

  chk_wp_no_set: assert property ( // [RULE15]
    wr_cause && !st_ff.watch_pending && !watch_match
      |=> !st_ff.watch_pending)
    else $error("software set watch pending");

  chk_hw_pending: assert property ( // [RULE17]
    s_cause_read |=> reg_rdata[escr_pkg::CA_HW +: HW_IRQS] ==
                     $past(hw_interrupt_pending))
    else $error("hardware pending bits wrong");

  chk_pin_follow: assert property ( // [RULE23]
    $stable(hw_irq_pin) [*3] |-> hw_interrupt_pending == hw_irq_pin)
    else $error("pending bits do not follow pins");

  chk_cause_zero: assert property ( // [RULE20]
    s_cause_read |=> (reg_rdata & escr_pkg::CAUSE_ZERO_MASK) == '0)
    else $error("cause reserved bits nonzero");

  chk_int_gate: assert property ( // [RULE21]
    // Request was formed from the pending bits of the cycle before
    ctl_out.int_req |-> st_ff.interrupt_master_enable &&
      |(st_ff.interrupt_mask &
        {$past(hw_interrupt_pending), st_ff.sw_interrupt_request}))
    else $error("interrupt request without enable and match");

  chk_um_untouched: assert property ( // [RULE1]
    exc_in.take && !wr_status |=> $stable(st_ff.user_mode_flag))
    else $error("exception changed user mode bit");

  chk_erl_effects: assert property ( // [RULE4]
    st_ff.error_level |-> ctl_out.kernel_mode && !ctl_out.int_req &&
                          ctl_out.exception_return_instr_use_error)
    else $error("error level effects missing");

  chk_exception_return_instr_error: assert property ( // [RULE4]
    s_return_at_error |=> !st_ff.error_level)
    else $error("return did not leave error level");

  chk_useg_map: assert property ( // [RULE5]
    ctl_out.useg_unmapped == st_ff.error_level)
    else $error("user segment mapping wrong");

  chk_exl_effects: assert property ( // [RULE7]
    st_ff.exception_level |-> ctl_out.kernel_mode && ctl_out.epc_hold)
    else $error("exception level effects missing");

  chk_refill_vec: assert property ( // [RULE8]
    ctl_out.refill_general == st_ff.exception_level)
    else $error("refill vector choice wrong");

  chk_ie_gate: assert property ( // [RULE9]
    !st_ff.interrupt_master_enable |-> !ctl_out.int_req)
    else $error("interrupt requested while disabled");

  chk_cause_ro: assert property ( // [RULE10]
    s_cause_write |=> $stable(st_ff.exc_code) && $stable(st_ff.cop_num) &&
                      $stable(st_ff.delay_slot_flag))
    else $error("software wrote a read-only cause field");

  chk_wp_clear: assert property ( // [RULE15]
    wr_cause && !reg_wdata[escr_pkg::CA_WP] && !watch_match
      |=> !st_ff.watch_pending)
    else $error("watch pending not cleared by write");

  chk_sw_write: assert property ( // [RULE18]
    s_cause_write |=> st_ff.sw_interrupt_request ==
                      $past(reg_wdata[escr_pkg::CA_SW +: 2]))
    else $error("software interrupt request not written");

endmodule

// >>> testbench/escr_pipe_model.sv
// Pipeline and interrupt-pin model facing the exception status logic
`timescale 1ns/100ps
module escr_pipe_model (
  input  wire logic           clk_sys,
  output escr_pkg::escr_exc_t exc_in,
  output logic                exception_return_instr,
  output logic                watch_match,
  output logic [5:0]          hw_irq_pin
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  initial begin
    exc_in = '0;
    exception_return_instr = 1'b0;
    watch_match = 1'b0;
    hw_irq_pin = 6'h00;
  end

  // ****************************************************************
  // Events: take, return and watch are single-cycle pulses, pins hold levels; all change only after a rising edge
  // ****************************************************************
  task automatic take(input logic rc, ds, input logic [1:0] cp,
                      input logic [4:0] cd);
    @(posedge clk_sys);
    exc_in <= '{1'b1, rc, 1'b0, ds, cp, cd};
    @(posedge clk_sys);
    exc_in <= '0;
  endtask

  task automatic ret();
    @(posedge clk_sys);
    exception_return_instr <= 1'b1;
    @(posedge clk_sys);
    exception_return_instr <= 1'b0;
  endtask

  task automatic watch();
    @(posedge clk_sys);
    watch_match <= 1'b1;
    @(posedge clk_sys);
    watch_match <= 1'b0;
  endtask

  // Pins are levels; bit i is hardware interrupt i
  task automatic pins(input logic [5:0] v);
    @(posedge clk_sys);
    hw_irq_pin <= v;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the exception status and cause registers
`timescale 1ns/100ps
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [7:0]  ST = escr_pkg::STATUS_OFF;
  localparam logic [7:0]  CA = escr_pkg::CAUSE_OFF;
  localparam logic [11:0] G  = escr_pkg::VEC_GENERAL;
  localparam logic [11:0] V  = escr_pkg::VEC_INT;
  localparam logic [31:0] M  = 32'hFFFF_FFFF;
  localparam logic [31:0] W  = 32'h0040_0000;
  logic                clk_sys;
  logic                rstn;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  escr_pkg::escr_exc_t exc_in;
  logic                exception_return_instr;
  logic                watch_match;
  logic [5:0]          hw_irq_pin;
  escr_pkg::escr_ctl_t ctl_out;
  logic                rd_seen = 1'b0;
  logic [31:0]         q_exp[$];
  logic [31:0]         q_msk[$];
  int                  n_fail = 0;
  int                  num_checks = 0;
  int                  seed;
  logic [7:0]          im;
  logic                ie;
  logic                ei;
  logic [1:0]          sw;
  logic [5:0]          hp;
  logic [4:0]          codes [13] = '{escr_pkg::EXC_INT, escr_pkg::EXC_ADEL,
    escr_pkg::EXC_ADES, escr_pkg::EXC_IBE, escr_pkg::EXC_DBE,
    escr_pkg::EXC_SYS, escr_pkg::EXC_BP, escr_pkg::EXC_RI, escr_pkg::EXC_CPU,
    escr_pkg::EXC_OV, escr_pkg::EXC_TR, escr_pkg::EXC_WATCH,
    escr_pkg::EXC_MCHK};

  escr_regs escr_regs_i (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exc_in(exc_in), .exception_return_instr(exception_return_instr),
    .watch_match(watch_match), .hw_irq_pin(hw_irq_pin), .ctl_out(ctl_out));
  escr_pipe_model escr_pipe_model_i (.clk_sys(clk_sys), .exc_in(exc_in),
    .exception_return_instr(exception_return_instr), .watch_match(watch_match), .hw_irq_pin(hw_irq_pin));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Checks and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Expected value is queued; the monitor compares it two cycles later
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q_exp.push_back(e);
    q_msk.push_back(m);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Flags: kernel, int_req, exception_return_instr_err, epc_hold, useg, watch, refill
  task automatic cc(input logic [6:0] f, input logic [11:0] v);
    @(negedge clk_sys);
    chk("ctl_out", 32'(ctl_out), 32'({f, v}));
  endtask

  function automatic logic [31:0] mk(input logic bd, input logic [1:0] cp,
    input logic wp, iv, input logic [5:0] hw, input logic [1:0] s,
    input logic [4:0] cd);
    return {bd, 1'b0, cp, 4'h0, iv, wp, 6'h00, hw, s, 1'b0, cd, 2'h0};
  endfunction

  // Read data stands one cycle only, zero at every other time
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      chk("reg_rdata", reg_rdata & q_msk[0], q_exp[0]);
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end else begin
      chk("idle_rdata", reg_rdata, 32'h0);
    end
    rd_seen <= reg_rd;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    // Short delay makes reset a clean falling edge the flops see
    #1 rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    seed = 32'h96F5;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    cc(7'h54, G);
    rd(ST, 32'h0000_0004, M);
    rd(CA, 32'h0, M);
    rd(8'h08, 32'h0, M);
    wr(ST, M);
    cc(7'h5D, G);
    rd(ST, 32'h0000_FF17, M);
    wr(ST, 32'h0000_0010);
    cc(7'h00, G);
    wr(CA, M);
    cc(7'h00, V);
    rd(CA, mk(1'b0, 2'h0, 1'b0, 1'b1, 6'h00, 2'h3, 5'h00),
       M);
    // Random mask, enable, software and pin levels
    for (int i = 0; i < 8; i++) begin
      im = 8'($random(seed));
      ie = 1'($random(seed));
      sw = 2'($random(seed));
      hp = 6'($random(seed));
      ei = ie & |(im & {hp, sw});
      wr(ST, {16'h0, im, 7'h08, ie});
      wr(CA, {22'h0, sw, 8'h00});
      escr_pipe_model_i.pins(hp);
      repeat (4) @(posedge clk_sys);
      cc({1'b0, ei, 5'h00}, G);
      rd(CA, mk(1'b0, 2'h0, 1'b0, 1'b0, hp, sw, 5'h00),
         M);
    end
    escr_pipe_model_i.pins(6'h00);
    wr(ST, 32'h0000_0111);
    wr(CA, 32'h0000_0100);
    cc(7'h20, G);
    escr_pipe_model_i.take(1'b0, 1'b1, 2'h2, escr_pkg::EXC_CPU);
    cc(7'h49, G);
    rd(ST, 32'h0000_0113, M);
    rd(CA, mk(1'b1, 2'h2, 1'b0, 1'b0, 6'h00, 2'h1, escr_pkg::EXC_CPU),
       M);
    // Nested exceptions: delay-slot flag frozen, code and unit reloaded
    for (int i = 0; i < 13; i++) begin
      escr_pipe_model_i.take(1'b0, 1'b0, 2'(i), codes[i]);
      rd(CA, mk(1'b1, 2'(i), 1'b0, 1'b0, 6'h00, 2'h1, codes[i]),
         M);
    end
    escr_pipe_model_i.ret();
    cc(7'h20, G);
    escr_pipe_model_i.take(1'b0, 1'b0, 2'h0, escr_pkg::EXC_SYS);
    rd(CA, mk(1'b0, 2'h0, 1'b0, 1'b0, 6'h00, 2'h1, escr_pkg::EXC_SYS),
       M);
    escr_pipe_model_i.ret();
    escr_pipe_model_i.take(1'b1, 1'b0, 2'h0, escr_pkg::EXC_INT);
    cc(7'h54, G);
    rd(ST, 32'h0000_0115, M);
    // Watch match deferred while a level is set
    escr_pipe_model_i.watch();
    rd(CA, W, W);
    cc(7'h54, G);
    wr(CA, 32'h0040_0100);
    rd(CA, W, W);
    escr_pipe_model_i.ret();
    cc(7'h22, G);
    wr(CA, 32'h0000_0100);
    cc(7'h20, G);
    rd(CA, 32'h0, W);
    escr_pipe_model_i.watch();
    rd(CA, 32'h0, W);
    repeat (3) @(posedge clk_sys);
    final_report();
  end
endmodule
